// file: hw/nps_defines.vh
// What this block does
// - No rise on a byte boundary: no program, no error flag, latch stays set.
// - Every address bit is captured on a rising serial clock edge.
// - Protected sector: no program, latch stays set, flag bits 1 and 4 set.
// - Program timeout clears the write enable latch and sets program fail.
// - Programming only clears ones to zeros, never sets zeros back to one.
// - Opcodes 02h, A2h, D2h: page, dual fast, extended dual fast program.
// - Opcodes 32h, 38h: quad fast and extended quad fast program.
// - Write in progress reads one while an accepted program runs.
// - Write enable latch clears at the end of every accepted program.
// - Write in progress clears on completion; status stays pollable meanwhile.
// - Suspend pauses a running program, resume continues it.
// - Bytes past the page end wrap to the start of the same page.
// - Over a page of data keeps only the latest page-size bytes.
// - Short data programs only the addressed bytes, rest of page untouched.
// - Bits travel on one, two or four lines by protocol and opcode.
`ifndef NPS_DEFINES_VH
`define NPS_DEFINES_VH

// Opcodes of the program family
`define NPS_OP_PAGE 8'h02
`define NPS_OP_DUAL 8'hA2
`define NPS_OP_XDUAL 8'hD2
`define NPS_OP_QUAD 8'h32
`define NPS_OP_XQUAD 8'h38

// Protocol selection
`define NPS_MODE_EXT 2'h0
`define NPS_MODE_DUAL 2'h1
`define NPS_MODE_QUAD 2'h2

// Field layout
`define NPS_ADDR_BITS 24
`define NPS_PAGE_BYTES 256
`define NPS_SECT_HI 23
`define NPS_SECT_LO 16
`define NPS_OFF_HI 7
`define NPS_PAGE_HI 23
`define NPS_PAGE_LO 8
`define NPS_BYTE_BITS 4'h8
`define NPS_ADDR_BITS_CNT 5'h18
// Scan position past the last page offset
`define NPS_SCAN_DONE 9'h100

// Timeout of a program operation, in microseconds, and clock rate in MHz
`define NPS_TPP_TIMEOUT_US 1800
`define NPS_CLK_MHZ 250

`endif

// file: hw/nps_page_program.v
`include "nps_defines.vh"

module nps_page_program #(
  parameter integer TIMEOUT_CYC = `NPS_TPP_TIMEOUT_US * `NPS_CLK_MHZ
) (
  input wire mclk,
  input wire rst_n,
  input wire spi_clk,
  input wire spi_cs_n,
  input wire [3:0] serial_data_lines,
  input wire [1:0] proto_mode,
  input wire wel_set,
  input wire wel_clr,
  input wire flag_clr,
  input wire pe_suspend,
  input wire pe_resume,
  input wire [255:0] sector_protect,
  output reg wip_q,
  output reg wel_q,
  output reg flag_prot_q,
  output reg flag_prog_err_q,
  output reg prog_susp_q,
  output reg arr_valid_q,
  output reg [23:0] arr_addr_q,
  output reg [7:0] arr_clr_mask_q,
  input wire arr_ready
);

  // Link-side states
  localparam [2:0] LS_IDLE = 3'h0;
  localparam [2:0] LS_CMD = 3'h1;
  localparam [2:0] LS_ADDR = 3'h2;
  localparam [2:0] LS_DATA = 3'h3;
  localparam [2:0] LS_SKIP = 3'h4;

  // Lanes used per edge for a phase
  function [2:0] nps_lanes;
    input [1:0] mode;
    input [7:0] op;
    input [1:0] phase;
    begin
      case (mode)
        `NPS_MODE_DUAL: nps_lanes = 3'h2;
        `NPS_MODE_QUAD: nps_lanes = 3'h4;
        default: begin
          if (phase == 2'h0) begin
            nps_lanes = 3'h1;
          end else if (op == `NPS_OP_XQUAD ||
                       (phase == 2'h2 && op == `NPS_OP_QUAD)) begin
            nps_lanes = 3'h4;
          end else if (op == `NPS_OP_XDUAL ||
                       (phase == 2'h2 && op == `NPS_OP_DUAL)) begin
            nps_lanes = 3'h2;
          end else begin
            nps_lanes = 3'h1;
          end
        end
      endcase
    end
  endfunction

  // Shift in one edge's worth of bits, MSB first
  function [23:0] nps_shift;
    input [23:0] cur;
    input [2:0] lanes;
    input [3:0] din;
    begin
      case (lanes)
        3'h2: nps_shift = {cur[21:0], din[1:0]};
        3'h4: nps_shift = {cur[19:0], din[3:0]};
        default: nps_shift = {cur[22:0], din[0]};
      endcase
    end
  endfunction

  // True for the five program-family opcodes
  function nps_is_prog;
    input [7:0] op;
    begin
      nps_is_prog = (op == `NPS_OP_PAGE) || (op == `NPS_OP_DUAL) ||
                    (op == `NPS_OP_XDUAL) || (op == `NPS_OP_QUAD) ||
                    (op == `NPS_OP_XQUAD);
    end
  endfunction

  // Reset release through two flops
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_i_n = rst_s2_q;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Pin synchronisers; edge detect looks only at the second stage onward
  reg [5:0] pin_s1_q;
  reg [5:0] pin_s2_q;
  reg sck_d1_q;
  reg cs_d1_q;

  always @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      pin_s1_q <= 6'h3F;
      pin_s2_q <= 6'h3F;
      sck_d1_q <= 1'b1;
      cs_d1_q <= 1'b1;
    end else begin
      pin_s1_q <= {spi_clk, spi_cs_n, serial_data_lines};
      pin_s2_q <= pin_s1_q;
      sck_d1_q <= pin_s2_q[5];
      cs_d1_q <= pin_s2_q[4];
    end
  end

  // Synchronised pins; serial clock edges count only while selected
  wire sck_s = pin_s2_q[5];
  wire cs_s = pin_s2_q[4];
  wire [3:0] dq_s = pin_s2_q[3:0];
  wire sck_rise = sck_s && !sck_d1_q && !cs_s;
  wire cs_rise = cs_s && !cs_d1_q;
  wire cs_fall = !cs_s && cs_d1_q;

  // Link-side capture state
  reg [2:0] ls_q;
  reg [7:0] op_q;
  reg [23:0] sh_q;
  reg [4:0] bit_cnt_q;
  reg [23:0] addr_q;
  reg [7:0] off_q;
  reg any_byte_q;
  reg [7:0] page_mem [0:255];
  reg [255:0] touched_q;

  // Per-edge phase, lane count and shifted value
  wire [1:0] phase = (ls_q == LS_CMD) ? 2'h0 : ((ls_q == LS_ADDR) ? 2'h1 : 2'h2);
  wire [2:0] lanes = nps_lanes(proto_mode, op_q, phase);
  wire [23:0] sh_next = nps_shift(sh_q, lanes, dq_s);
  wire [4:0] cnt_next = bit_cnt_q + {2'h0, lanes};
  wire byte_done = (cnt_next[3:0] == `NPS_BYTE_BITS);

  // Accept only on a whole final byte with chip select raised
  wire start_ok = cs_rise && (ls_q == LS_DATA) && any_byte_q &&
                  (bit_cnt_q == 5'h0) && wel_q && !wip_q;
  wire prot_hit = sector_protect[addr_q[`NPS_SECT_HI:`NPS_SECT_LO]];

  // Program engine state
  reg [8:0] scan_q;
  reg [31:0] tmo_q;
  reg v1_q;
  reg [23:0] e1_addr_q;
  reg [7:0] e1_mask_q;
  wire drain_go = wip_q && !prog_susp_q;
  wire scan_end = scan_q[8];
  wire in_ready = !v1_q;
  wire [7:0] scan_idx = scan_q[7:0];
  wire in_valid = drain_go && !scan_end && touched_q[scan_idx];
  wire push = in_valid && in_ready;
  wire pop = arr_valid_q && arr_ready;
  // Word for the array: page of the start address, offset from the scan
  wire [23:0] in_addr = {addr_q[`NPS_PAGE_HI:`NPS_PAGE_LO], scan_idx};
  wire [7:0] in_mask = ~page_mem[scan_idx];
  // Budget frozen while suspended, so a long pause cannot fail a program
  wire timed_out = drain_go && (tmo_q == TIMEOUT_CYC - 1);
  wire prog_done = wip_q && scan_end && !arr_valid_q && !v1_q;

  // Capture of command, address and data on serial clock rises
  always @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      ls_q <= LS_IDLE;
      op_q <= 8'h00;
      sh_q <= 24'h000000;
      bit_cnt_q <= 5'h00;
      addr_q <= 24'h000000;
      off_q <= 8'h00;
      any_byte_q <= 1'b0;
    end else if (cs_s) begin
      ls_q <= LS_IDLE;
      bit_cnt_q <= 5'h00;
    end else if (cs_fall) begin
      ls_q <= LS_CMD;
      bit_cnt_q <= 5'h00;
      sh_q <= 24'h000000;
      any_byte_q <= 1'b0;
    end else if (sck_rise) begin
      sh_q <= sh_next;
      case (ls_q)
        LS_CMD: begin
          bit_cnt_q <= byte_done ? 5'h00 : cnt_next;
          if (byte_done) begin
            op_q <= sh_next[7:0];
            // Busy or no latch: command dropped silently
            if (nps_is_prog(sh_next[7:0]) && wel_q && !wip_q) begin
              ls_q <= LS_ADDR;
            end else begin
              ls_q <= LS_SKIP;
            end
          end
        end
        LS_ADDR: begin
          if (cnt_next == `NPS_ADDR_BITS_CNT) begin
            addr_q <= sh_next;
            off_q <= sh_next[`NPS_OFF_HI:0];
            bit_cnt_q <= 5'h00;
            ls_q <= LS_DATA;
          end else begin
            bit_cnt_q <= cnt_next;
          end
        end
        LS_DATA: begin
          bit_cnt_q <= byte_done ? 5'h00 : cnt_next;
          if (byte_done) begin
            off_q <= off_q + 8'h01;
            any_byte_q <= 1'b1;
          end
        end
        LS_SKIP: bit_cnt_q <= 5'h00;
        default: ls_q <= LS_SKIP;
      endcase
    end
  end

  // Page buffer; a later byte to the same offset replaces the earlier one
  always @(posedge mclk) begin
    if (!cs_s && sck_rise && ls_q == LS_DATA && byte_done) begin
      page_mem[off_q] <= sh_next[7:0];
    end
  end

  // Marks of written offsets; cleared at each new command that starts while not busy
  always @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      touched_q <= {`NPS_PAGE_BYTES{1'b0}};
    end else if (cs_fall && !wip_q) begin
      touched_q <= {`NPS_PAGE_BYTES{1'b0}};
    end else if (!cs_s && sck_rise && ls_q == LS_DATA && byte_done) begin
      touched_q[off_q] <= 1'b1;
    end
  end

  // Status: latch, busy, error flags; a set wins over a clear, except that program end clears the latch and suspend even with wel_set or pe_suspend
  always @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      wel_q <= 1'b0;
      wip_q <= 1'b0;
      flag_prot_q <= 1'b0;
      flag_prog_err_q <= 1'b0;
      prog_susp_q <= 1'b0;
    end else begin
      if (start_ok && prot_hit) begin
        flag_prot_q <= 1'b1;
        flag_prog_err_q <= 1'b1;
      end else if (timed_out) begin
        flag_prog_err_q <= 1'b1;
      end else if (flag_clr) begin
        flag_prot_q <= 1'b0;
        flag_prog_err_q <= 1'b0;
      end
      if (start_ok && !prot_hit) begin
        wip_q <= 1'b1;
      end else if (timed_out || prog_done) begin
        wip_q <= 1'b0;
      end
      // Latch survives rejection and missing chip select rise
      if (timed_out || prog_done) begin
        wel_q <= 1'b0;
      end else if (wel_set) begin
        wel_q <= 1'b1;
      end else if (wel_clr && !wip_q) begin
        wel_q <= 1'b0;
      end
      if (timed_out || prog_done) begin
        prog_susp_q <= 1'b0;
      end else if (wip_q && pe_suspend) begin
        prog_susp_q <= 1'b1;
      end else if (pe_resume) begin
        prog_susp_q <= 1'b0;
      end
    end
  end

  // Scan of the page buffer and time budget; both halt while suspended
  always @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      scan_q <= `NPS_SCAN_DONE;
      tmo_q <= 32'h00000000;
    end else if (start_ok && !prot_hit) begin
      scan_q <= 9'h000;
      tmo_q <= 32'h00000000;
    end else if (timed_out) begin
      scan_q <= `NPS_SCAN_DONE;
    end else if (drain_go) begin
      tmo_q <= tmo_q + 32'h00000001;
      // Skip untouched bytes; stall on a full buffer
      if (!scan_end && (push || !touched_q[scan_idx])) begin
        scan_q <= scan_q + 9'h001;
      end
    end
  end

  // Two-entry buffer toward the array; head entry drives the outputs
  always @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      arr_valid_q <= 1'b0;
      arr_addr_q <= 24'h000000;
      arr_clr_mask_q <= 8'h00;
      v1_q <= 1'b0;
      e1_addr_q <= 24'h000000;
      e1_mask_q <= 8'h00;
    end else if (timed_out) begin
      arr_valid_q <= 1'b0;
      v1_q <= 1'b0;
    end else if (pop) begin
      if (v1_q) begin
        arr_addr_q <= e1_addr_q;
        arr_clr_mask_q <= e1_mask_q;
        v1_q <= 1'b0;
      end else if (push) begin
        arr_addr_q <= in_addr;
        arr_clr_mask_q <= in_mask;
      end else begin
        arr_valid_q <= 1'b0;
      end
    end else if (push) begin
      if (!arr_valid_q) begin
        arr_valid_q <= 1'b1;
        arr_addr_q <= in_addr;
        arr_clr_mask_q <= in_mask;
      end else begin
        v1_q <= 1'b1;
        e1_addr_q <= in_addr;
        e1_mask_q <= in_mask;
      end
    end
  end

endmodule

// file: tb/nps_page_program_props.sv
module nps_page_program_props (
  input wire mclk,
  input wire rst_n,
  input wire spi_cs_n,
  input wire wip_q,
  input wire wel_q,
  input wire flag_prot_q,
  input wire flag_prog_err_q,
  input wire prog_susp_q,
  input wire arr_valid_q,
  input wire [23:0] arr_addr_q,
  input wire arr_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Busy only starts from a set latch, after the select has gone high
  AST_WIP_WEL: assert property ($rose(wip_q) |->
    $past(wel_q) && spi_cs_n && $past(spi_cs_n, 2))
    else $error("busy started without latch or select");
  AST_END: assert property ($fell(wip_q) |-> !wel_q)
    else $error("latch still set after program");
  AST_PROT: assert property ($rose(flag_prot_q) |-> flag_prog_err_q && wel_q && !wip_q)
    else $error("protected reject flags wrong");
  AST_TO: assert property ($rose(flag_prog_err_q) && !flag_prot_q |-> !wip_q && !wel_q)
    else $error("fail flag without ending program");
  AST_IDLE: assert property (!wip_q |-> !arr_valid_q)
    else $error("array write while not busy");
  AST_HOLD: assert property (arr_valid_q && !arr_ready |=>
    !wip_q || (arr_valid_q && $stable(arr_addr_q)))
    else $error("stalled word changed");
  AST_ASCEND: assert property ((arr_valid_q && arr_ready) ##1 arr_valid_q |->
    arr_addr_q[23:8] == $past(arr_addr_q[23:8]) && arr_addr_q[7:0] > $past(arr_addr_q[7:0]))
    else $error("word left the page or out of order");
  AST_SUSP: assert property (prog_susp_q |-> wip_q)
    else $error("suspended while idle");
endmodule

// file: tb/nps_host_model.sv
`include "nps_defines.vh"
module nps_host_model (
  input wire mclk,
  output logic spi_clk = 1'b0,
  output logic spi_cs_n = 1'b1,
  output logic [3:0] sdl = 4'hA
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half of the 160 ns link period
  task automatic hp;
    repeat (20) @(negedge mclk);
  endtask
  // Lanes for phase 0 command, 1 address, 2 data
  function automatic int ln(logic [1:0] m, logic [7:0] op, int ph);
    if (m != `NPS_MODE_EXT) return (m == `NPS_MODE_DUAL) ? 2 : 4;
    if (ph == 0) return 1;
    if (ph == 1) return op == `NPS_OP_XDUAL ? 2 : (op == `NPS_OP_XQUAD ? 4 : 1);
    if (op == `NPS_OP_PAGE) return 1;
    return (op == `NPS_OP_DUAL || op == `NPS_OP_XDUAL) ? 2 : 4;
  endfunction
  // MSB first; clock stays low outside frames
  task automatic shb(logic [7:0] v, int l, int nb);
    for (int b = 7; b > 7 - nb; b -= l) begin
      sdl = 4'((v >> (b - l + 1)) & ((1 << l) - 1));
      hp();
      spi_clk = 1'b1;
      hp();
      spi_clk = 1'b0;
    end
  endtask
  // Whole frame; cut sends half of the last byte
  task automatic frame(logic [1:0] m, logic [7:0] op, logic [23:0] a, int n,
                       logic [7:0] d0, bit cut);
    spi_cs_n = 1'b0;
    hp();
    shb(op, ln(m, op, 0), 8);
    for (int i = 2; i >= 0; i--) shb(a[i*8 +: 8], ln(m, op, 1), 8);
    for (int i = 0; i < n; i++) begin
      // A second pass over the page carries different data
      shb(d0 + 8'(i) + 8'(i >> 8), ln(m, op, 2), (cut && i == n - 1) ? 4 : 8);
    end
    hp();
    spi_cs_n = 1'b1;
    sdl = ~sdl; // Released lines must not look held
    hp();
  endtask
endmodule

// file: tb/nps_page_program_tb.sv
`include "nps_defines.vh"
module nps_page_program_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, wel_set = 1'b0, flag_clr = 1'b0;
  logic pe_suspend = 1'b0, pe_resume = 1'b0, arr_ready = 1'b0, wel_clr = 1'b0;
  logic [1:0] proto_mode = 2'h0;
  logic [255:0] sector_protect = 256'h4;
  logic spi_clk, spi_cs_n;
  logic [3:0] sdl;
  wire wip_q, wel_q, flag_prot_q, flag_prog_err_q, prog_susp_q, arr_valid_q;
  wire [23:0] arr_addr_q;
  wire [7:0] arr_clr_mask_q;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  logic [7:0] mem [int];
  logic [7:0] ops [5] = '{`NPS_OP_PAGE, `NPS_OP_DUAL, `NPS_OP_XDUAL, `NPS_OP_QUAD, `NPS_OP_XQUAD};
  nps_host_model i_nps_host_model (.mclk(mclk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .sdl(sdl));
  nps_page_program #(.TIMEOUT_CYC(600)) i_nps_page_program (
    .mclk(mclk), .rst_n(rst_n), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .serial_data_lines(sdl), .proto_mode(proto_mode), .wel_set(wel_set), .wel_clr(wel_clr),
    .flag_clr(flag_clr), .pe_suspend(pe_suspend), .pe_resume(pe_resume),
    .sector_protect(sector_protect), .wip_q(wip_q), .wel_q(wel_q), .flag_prot_q(flag_prot_q),
    .flag_prog_err_q(flag_prog_err_q), .prog_susp_q(prog_susp_q), .arr_valid_q(arr_valid_q),
    .arr_addr_q(arr_addr_q), .arr_clr_mask_q(arr_clr_mask_q), .arr_ready(arr_ready));
  initial forever #2 mclk = ~mclk;
  function automatic logic [7:0] rd(logic [23:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction
  // Array model clears bits only; cycle ceiling cuts a hang
  always @(posedge mclk) begin
    cyc++;
    if (arr_valid_q === 1'b1 && arr_ready) begin
      mem[int'(arr_addr_q)] = rd(arr_addr_q) & ~arr_clr_mask_q;
    end
    if (cyc == 60000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask
  // Array stalls through the frame so the buffer fills; hold keeps it stalled
  task automatic run(logic [1:0] m, logic [7:0] op, logic [23:0] a, int n, logic [7:0] d0,
                     bit cut, bit hold, bit busy);
    proto_mode = m;
    arr_ready = 1'b0;
    i_nps_host_model.frame(m, op, a, n, d0, cut);
    chk("wip", {7'h0, busy}, {7'h0, wip_q});
    arr_ready = !hold;
    for (int k = 0; k < 2000 && wip_q !== 1'b0 && !hold; k++) @(negedge mclk);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    for (int i = 0; i < 5; i++) begin
      pulse(wel_set);
      run(`NPS_MODE_EXT, ops[i], {16'h0001 + 16'(i), 8'h10}, 2, 8'hA0 + 8'(i), 0, 0, 1);
      chk("wel", 8'h00, {7'h0, wel_q});
      chk("b0", 8'hA0 + 8'(i), rd({16'h0001 + 16'(i), 8'h10}));
      chk("b1", 8'hA1 + 8'(i), rd({16'h0001 + 16'(i), 8'h11}));
      chk("b2", 8'hFF, rd({16'h0001 + 16'(i), 8'h12}));
    end
    $display("test opcodes done");
    pulse(wel_set);
    run(`NPS_MODE_QUAD, `NPS_OP_QUAD, 24'h0003FE, 4, 8'h3C, 0, 0, 1);
    pulse(wel_set);
    run(`NPS_MODE_DUAL, `NPS_OP_DUAL, 24'h0003FE, 1, 8'hC3, 0, 0, 1);
    chk("fe", 8'h00, rd(24'h0003FE));
    chk("ff", 8'h3D, rd(24'h0003FF));
    chk("00", 8'h3E, rd(24'h000300));
    chk("01", 8'h3F, rd(24'h000301));
    $display("test wrap done");
    pulse(wel_set);
    pulse(wel_clr);
    chk("welclr", 8'h00, {7'h0, wel_q});
    run(`NPS_MODE_EXT, `NPS_OP_PAGE, 24'h000500, 1, 8'h00, 0, 0, 0);
    pulse(wel_set);
    run(`NPS_MODE_EXT, `NPS_OP_PAGE, 24'h000500, 2, 8'h00, 1, 0, 0);
    chk("cutwel", 8'h01, {7'h0, wel_q});
    chk("cutflg", 8'h00, {6'h0, flag_prot_q, flag_prog_err_q});
    chk("cutmem", 8'hFF, rd(24'h000500));
    run(`NPS_MODE_EXT, `NPS_OP_PAGE, 24'h020000, 1, 8'h00, 0, 0, 0);
    chk("prot", 8'h03, {6'h0, flag_prot_q, flag_prog_err_q});
    chk("protwel", 8'h01, {7'h0, wel_q});
    pulse(flag_clr);
    chk("clr", 8'h00, {6'h0, flag_prot_q, flag_prog_err_q});
    $display("test rejects done");
    run(`NPS_MODE_EXT, `NPS_OP_PAGE, 24'h000600, 2, 8'h55, 0, 1, 1);
    pulse(pe_suspend);
    chk("susp", 8'h01, {7'h0, prog_susp_q});
    pulse(wel_clr);
    chk("busywel", 8'h01, {7'h0, wel_q});
    repeat (700) @(negedge mclk);
    chk("frozen", 8'h01, {7'h0, wip_q});
    pulse(pe_resume);
    repeat (700) @(negedge mclk);
    chk("tmo", 8'h01, {6'h0, wel_q, flag_prog_err_q});
    chk("tmowip", 8'h00, {7'h0, wip_q});
    $display("test timeout done");
    pulse(wel_set);
    run(`NPS_MODE_QUAD, `NPS_OP_QUAD, 24'h000700, 257, 8'h20, 0, 0, 1);
    chk("ovr00", 8'h21, rd(24'h000700));
    chk("ovr01", 8'h21, rd(24'h000701));
    chk("ovrff", 8'h1F, rd(24'h0007FF));
    $display("test overflow done");
    results();
  end
endmodule
bind nps_page_program nps_page_program_props i_nps_page_program_props (
  .mclk(mclk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .wip_q(wip_q), .wel_q(wel_q),
  .flag_prot_q(flag_prot_q), .flag_prog_err_q(flag_prog_err_q), .prog_susp_q(prog_susp_q),
  .arr_valid_q(arr_valid_q), .arr_addr_q(arr_addr_q), .arr_ready(arr_ready));
